// [rtl/bdr_defs.svh]
// Constants for the boot diagnostic report block
`ifndef BDR_DEFS_SVH
`define BDR_DEFS_SVH

// Packet header and structure identifier
`define BDR_PKT_LEN        16'h0257
`define BDR_SVC_TYPE       8'h03
`define BDR_SVC_SUB        8'h1A
`define BDR_SID_BOOT       16'h0001

// Frame word indices (header words come first)
`define BDR_HDR_WORDS      9'h002
`define BDR_F_LEN          9'h000
`define BDR_F_SVC          9'h001
`define BDR_FRAME_LAST     9'h127

// Data word indices, byte offset divided by two
`define BDR_W_SID          9'h000
`define BDR_W_SBI          9'h001
`define BDR_W_FPGA         9'h002
`define BDR_W_PROM         9'h003
`define BDR_W_PM_MAP       9'h004
`define BDR_W_BAD          9'h084
`define BDR_W_DMRAM        9'h0A4
`define BDR_W_EE_MAP       9'h0A5
`define BDR_W_ASW          9'h125

// Memory block geometry
`define BDR_PM_BLK_LSB     6
`define BDR_EE_BLK_LSB     8
`define BDR_BAD_MAX        5'h10

// Serial bus interface test phases and patterns
`define BDR_PH_INIT        3'h0
`define BDR_PH_5554        3'h1
`define BDR_PH_ONE         3'h2
`define BDR_PH_AAAA        3'h3
`define BDR_PH_5555        3'h4
`define BDR_PH_ZERO        3'h5
`define BDR_REG_NOT_SET    3'h3
`define BDR_PAT_AAAA       16'hAAAA
`define BDR_PAT_5555       16'h5555
`define BDR_PAT_ZERO       16'h0000

// FPGA register reset values
`define BDR_FPGA_EXP_3     32'h01FF0000
`define BDR_FPGA_EXP_56    32'h00640000
`define BDR_FPGA_EXP_8     32'h0A5AA5A5
`define BDR_FPGA_EXP_0     32'h00000000

// Wishbone register byte offsets
`define BDR_A_CTRL         8'h00
`define BDR_A_STATUS       8'h04
`define BDR_A_SBI          8'h08
`define BDR_A_FPGA         8'h0C
`define BDR_A_IRQ_STAT     8'h10
`define BDR_A_IRQ_MASK     8'h14

// Field positions and reset values
`define BDR_CTRL_EN        0
`define BDR_CTRL_CLR       1
`define BDR_CTRL_EN_RST    1'b1
`define BDR_IRQ_SENT       0
`define BDR_IRQ_FAULT      1
`define BDR_IRQ_W          2

`endif

// [rtl/bdr_pkg.sv]
// Types for the boot diagnostic report block
package bdr_pkg;

    typedef enum logic [0:0] {
        BDR_IDLE = 1'b0,
        BDR_SEND = 1'b1
    } bdr_fstate_t;

    typedef struct packed {
        bdr_fstate_t state;
        logic [8:0]  cnt;
        logic        valid;
        logic [15:0] data;
        logic        last;
        logic        done;
    } bdr_frm_st_t;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        logic                 en;
        logic                 sent;
        logic                 busy;
        logic                 start;
        logic [1:0]           irq_stat;
        logic [1:0]           irq_mask;
        logic                 irq;
        logic [5:0]           sbi_diag;
        logic [15:0]          fpga_diag;
        logic                 prom_err;
        logic [1:0]           dmram;
        logic                 asw_err;
        logic [4:0]           bad_cnt;
        logic [15:0][31:0]    bad_addr;
        logic [127:0][15:0]   pm_map;
        logic [127:0][15:0]   ee_map;
    } bdr_core_st_t;

endpackage : bdr_pkg

// [rtl/bdr_frame_if.sv]
// Link between report core and word framer
`timescale 1ns/10ps
interface bdr_frame_if;
    logic        start;
    logic        ready;
    logic [15:0] word;
    logic [8:0]  idx;
    logic        valid;
    logic [15:0] data;
    logic        last;
    logic        done;
    logic        busy;

    modport core   (output start, output ready, output word, input idx, input valid, input data, input last,
                    input done, input busy);
    modport framer (input start, input ready, input word, output idx, output valid, output data, output last,
                    output done, output busy);
endinterface : bdr_frame_if

// [rtl/bdr_framer.sv]
// Word framer that walks the report out one word per handshake
`timescale 1ns/10ps
`include "bdr_defs.svh"
module bdr_framer (
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    bdr_frame_if.framer  fr
);
    bdr_pkg::bdr_frm_st_t q;
    bdr_pkg::bdr_frm_st_t n;

    // Index of the word to load next; core answers combinationally
    assign fr.idx   = (q.state == bdr_pkg::BDR_IDLE) ? `BDR_F_LEN : 9'(q.cnt + 9'h001);
    assign fr.valid = q.valid;
    assign fr.data  = q.data;
    assign fr.last  = q.last;
    assign fr.done  = q.done;
    assign fr.busy  = (q.state == bdr_pkg::BDR_SEND);

    always_comb begin
        n      = q;
        n.done = 1'b0;
        case (q.state)
            bdr_pkg::BDR_IDLE: begin
                if (fr.start) begin
                    n.state = bdr_pkg::BDR_SEND;
                    n.cnt   = `BDR_F_LEN;
                    n.valid = 1'b1;
                    n.data  = fr.word;
                    n.last  = 1'b0;
                end
            end
            bdr_pkg::BDR_SEND: begin
                if (fr.ready) begin
                    if (q.last) begin
                        n.state = bdr_pkg::BDR_IDLE;
                        n.valid = 1'b0;
                        n.last  = 1'b0;
                        n.done  = 1'b1;
                    end else begin
                        // Contiguous big-endian words, no gaps
                        n.cnt  = 9'(q.cnt + 9'h001);
                        n.data = fr.word;
                        n.last = (9'(q.cnt + 9'h001) == `BDR_FRAME_LAST);
                    end
                end
            end
            default: begin
                n.state = bdr_pkg::BDR_IDLE;
                n.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule : bdr_framer

// [rtl/bdr_core.sv]
// Boot diagnostic report: result collection, report framing and Wishbone registers
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "bdr_defs.svh"
module bdr_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        sbi_obs_valid_i,
    input  wire logic [2:0]  sbi_obs_phase_i,
    input  wire logic [2:0]  sbi_obs_reg_i,
    input  wire logic [15:0] sbi_obs_data_i,
    input  wire logic        fpga_obs_valid_i,
    input  wire logic [3:0]  fpga_obs_idx_i,
    input  wire logic [31:0] fpga_obs_data_i,
    input  wire logic        prom_fail_i,
    input  wire logic        pm_err_valid_i,
    input  wire logic [16:0] pm_err_addr_i,
    input  wire logic        dmram_wr_fail_i,
    input  wire logic        dmram_restore_fail_i,
    input  wire logic        ee_err_valid_i,
    input  wire logic [18:0] ee_err_addr_i,
    input  wire logic        tests_done_i,
    input  wire logic        asw_copy_done_i,
    input  wire logic        asw_copy_fail_i,
    output logic             tx_valid_o,
    output logic [15:0]      tx_word_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i
);
    bdr_pkg::bdr_core_st_t q;
    bdr_pkg::bdr_core_st_t n;
    bdr_frame_if           fr ();

    bdr_framer u_framer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .fr    (fr)
    );

    // Expected reset readback of the sixteen FPGA registers
    function automatic logic [31:0] fpga_expected(input logic [3:0] idx);
        logic [31:0] v;
        case (idx)
            4'h3:       v = `BDR_FPGA_EXP_3;
            4'h5, 4'h6: v = `BDR_FPGA_EXP_56;
            4'h8:       v = `BDR_FPGA_EXP_8;
            default:    v = `BDR_FPGA_EXP_0;
        endcase
        return v;
    endfunction : fpga_expected

    // Block number to one-hot flag inside its bitmap word
    function automatic logic [15:0] blk_flag(input logic [10:0] blk);
        logic [15:0] f;
        f = 16'h0000;
        f[blk[3:0]] = 1'b1;
        return f;
    endfunction : blk_flag

    // Verdict of one serial bus interface readback; bit index per phase
    function automatic logic [5:0] sbi_verdict(input logic [2:0] ph, input logic [2:0] rg,
                                               input logic [15:0] d);
        logic [5:0] v;
        v = 6'h00;
        case (ph)
            `BDR_PH_INIT: v[0] = (d != `BDR_PAT_ZERO);
            `BDR_PH_5554: v[1] = (rg == `BDR_REG_NOT_SET) ?
                                 (d != `BDR_PAT_ZERO) : (d == `BDR_PAT_ZERO);
            `BDR_PH_ONE:  v[2] = (d != `BDR_PAT_ZERO);
            `BDR_PH_AAAA: v[3] = (d != `BDR_PAT_AAAA);
            `BDR_PH_5555: v[4] = (d != `BDR_PAT_5555);
            `BDR_PH_ZERO: v[5] = (d != `BDR_PAT_ZERO);
            default:      v    = 6'h00;
        endcase
        return v;
    endfunction : sbi_verdict

    // Report data word at a given data index
    logic [8:0]  d_idx;
    logic [8:0]  d_off;
    logic [15:0] d_word;
    always_comb begin
        d_idx  = 9'(fr.idx - `BDR_HDR_WORDS);
        d_off  = 9'h000;
        d_word = 16'h0000;
        if (d_idx == `BDR_W_SID) begin
            d_word = `BDR_SID_BOOT;
        end else if (d_idx == `BDR_W_SBI) begin
            d_word = {10'h000, q.sbi_diag};
        end else if (d_idx == `BDR_W_FPGA) begin
            d_word = q.fpga_diag;
        end else if (d_idx == `BDR_W_PROM) begin
            d_word = {15'h0000, q.prom_err};
        end else if (d_idx < `BDR_W_BAD) begin
            d_off  = 9'(d_idx - `BDR_W_PM_MAP);
            d_word = q.pm_map[d_off[6:0]];
        end else if (d_idx < `BDR_W_DMRAM) begin
            d_off  = 9'(d_idx - `BDR_W_BAD);
            // Even word carries the high half of the address
            d_word = d_off[0] ? q.bad_addr[d_off[4:1]][15:0]
                              : q.bad_addr[d_off[4:1]][31:16];
        end else if (d_idx == `BDR_W_DMRAM) begin
            d_word = {14'h0000, q.dmram};
        end else if (d_idx < `BDR_W_ASW) begin
            d_off  = 9'(d_idx - `BDR_W_EE_MAP);
            d_word = q.ee_map[d_off[6:0]];
        end else if (d_idx == `BDR_W_ASW) begin
            d_word = {15'h0000, q.asw_err};
        end
    end

    // Header words ahead of the application data
    assign fr.word  = (fr.idx == `BDR_F_LEN) ? `BDR_PKT_LEN :
                      (fr.idx == `BDR_F_SVC) ? {`BDR_SVC_TYPE, `BDR_SVC_SUB} : d_word;
    assign fr.start = q.start;
    assign fr.ready = tx_ready_i;

    assign wb_dat_o   = q.rdat;
    assign wb_ack_o   = q.ack;
    assign irq_o      = q.irq;
    assign tx_valid_o = fr.valid;
    assign tx_word_o  = fr.data;
    assign tx_last_o  = fr.last;

    logic        wb_req;
    logic        wb_wr;
    logic [5:0]  sbi_set;
    logic [15:0] fpga_set;
    logic [10:0] pm_blk;
    logic [10:0] ee_blk;
    logic        clr;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;
    logic        fault_ev;
    logic        trig;

    always_comb begin
        n        = q;
        wb_req   = wb_cyc_i & wb_stb_i & ~q.ack;
        wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
        clr      = wb_wr & (wb_adr_i == `BDR_A_CTRL) & wb_dat_i[`BDR_CTRL_CLR];
        sbi_set  = sbi_obs_valid_i ? sbi_verdict(sbi_obs_phase_i, sbi_obs_reg_i, sbi_obs_data_i) : 6'h00;
        fpga_set = 16'h0000;
        pm_blk   = pm_err_addr_i[`BDR_PM_BLK_LSB +: 11];
        ee_blk   = ee_err_addr_i[`BDR_EE_BLK_LSB +: 11];
        irq_set  = 2'b00;
        irq_clr  = 2'b00;
        if (fpga_obs_valid_i && (fpga_obs_data_i != fpga_expected(fpga_obs_idx_i))) begin
            fpga_set[fpga_obs_idx_i] = 1'b1;
        end

        // Result collection; a clear wipes every collected result but does not rearm the report
        if (clr) begin
            n.sbi_diag  = 6'h00;
            n.fpga_diag = 16'h0000;
            n.prom_err  = 1'b0;
            n.dmram     = 2'b00;
            n.asw_err   = 1'b0;
            n.bad_cnt   = 5'h00;
            n.bad_addr  = '0;
            n.pm_map    = '0;
            n.ee_map    = '0;
        end else begin
            n.sbi_diag  = q.sbi_diag | sbi_set;
            n.fpga_diag = q.fpga_diag | fpga_set;
            n.prom_err  = q.prom_err | prom_fail_i;
            n.dmram     = q.dmram | {dmram_restore_fail_i, dmram_wr_fail_i};
            n.asw_err   = q.asw_err | (asw_copy_done_i & asw_copy_fail_i);
            if (pm_err_valid_i) begin
                // Flags accumulate; several blocks may fail together
                n.pm_map[pm_blk[10:4]] = q.pm_map[pm_blk[10:4]] | blk_flag(pm_blk);
                if (q.bad_cnt < `BDR_BAD_MAX) begin
                    n.bad_addr[q.bad_cnt[3:0]] = {15'h0000, pm_err_addr_i};
                    n.bad_cnt = 5'(q.bad_cnt + 5'h01);
                end
            end
            if (ee_err_valid_i) begin
                n.ee_map[ee_blk[10:4]] = q.ee_map[ee_blk[10:4]] | blk_flag(ee_blk);
            end
        end

        // Single emission after tests or after the image copy
        trig    = (tests_done_i | asw_copy_done_i) & q.en & ~q.sent & ~q.busy;
        n.start = trig;
        if (trig) begin
            n.sent = 1'b1;
            n.busy = 1'b1;
        end
        if (fr.done) begin
            n.busy = 1'b0;
        end

        // Interrupt status: set wins over a write-one clear
        fault_ev = (|sbi_set) | (|fpga_set) | prom_fail_i | pm_err_valid_i | dmram_wr_fail_i |
                   dmram_restore_fail_i | ee_err_valid_i | (asw_copy_done_i & asw_copy_fail_i);
        irq_set[`BDR_IRQ_SENT]  = fr.done;
        irq_set[`BDR_IRQ_FAULT] = fault_ev;
        if (wb_wr && (wb_adr_i == `BDR_A_IRQ_STAT)) begin
            irq_clr = wb_dat_i[`BDR_IRQ_W-1:0];
        end
        n.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
        n.irq      = |(n.irq_stat & n.irq_mask);

        // Wishbone slave: ack one cycle after the strobe, dropped the next
        n.ack = wb_req;
        if (wb_wr) begin
            case (wb_adr_i)
                `BDR_A_CTRL:     n.en       = wb_dat_i[`BDR_CTRL_EN];
                `BDR_A_IRQ_MASK: n.irq_mask = wb_dat_i[`BDR_IRQ_W-1:0];
                default:         n.en       = q.en;
            endcase
        end
        n.irq = |(n.irq_stat & n.irq_mask);
        n.rdat = 32'h00000000;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `BDR_A_CTRL:     n.rdat = {31'h00000000, q.en};
                `BDR_A_STATUS:   n.rdat = {23'h000000, q.bad_cnt, 2'b00, q.busy, q.sent};
                `BDR_A_SBI:      n.rdat = {26'h0000000, q.sbi_diag};
                `BDR_A_FPGA:     n.rdat = {16'h0000, q.fpga_diag};
                `BDR_A_IRQ_STAT: n.rdat = {30'h00000000, q.irq_stat};
                `BDR_A_IRQ_MASK: n.rdat = {30'h00000000, q.irq_mask};
                default:         n.rdat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q    <= '0;
            q.en <= `BDR_CTRL_EN_RST;
        end else begin
            q <= n;
        end
    end
endmodule : bdr_core

// [verif/bdr_core_chk.sv]
// Port-level assertions for the boot diagnostic report block
`timescale 1ns/10ps
module bdr_core_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        tests_done_i,
    input wire logic        asw_copy_done_i,
    input wire logic        tx_valid_o,
    input wire logic [15:0] tx_word_o,
    input wire logic        tx_last_o,
    input wire logic        tx_ready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [8:0] cnt_r;
    logic       trig_r;
    logic       done_r;
    wire        take = tx_valid_o && tx_ready_i;
    wire        trig = tests_done_i || asw_copy_done_i;
    // Word counter lets header and tail words be pinned by position
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 9'h000;
            trig_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (take) cnt_r <= cnt_r + 9'h001;
            if (trig) trig_r <= 1'b1;
            if (take && tx_last_o) done_r <= 1'b1;
        end
    end
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    report_start_a: assert property (trig && !trig_r |-> ##2 tx_valid_o && tx_word_o == 16'h0257)
        else $error("report did not start two cycles after trigger");
    no_early_a: assert property (!trig_r |-> !tx_valid_o)
        else $error("report words before any trigger");
    send_once_a: assert property (done_r |-> !tx_valid_o)
        else $error("report words after report finished");
    svc_word_a: assert property (tx_valid_o && cnt_r == 9'd1 |-> tx_word_o == 16'h031A)
        else $error("service word wrong");
    sid_word_a: assert property (tx_valid_o && cnt_r == 9'd2 |-> tx_word_o == 16'h0001)
        else $error("structure id wrong");
    last_pos_a: assert property (tx_valid_o |-> tx_last_o == (cnt_r == 9'd295))
        else $error("last flag not on word 295");
    word_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_word_o))
        else $error("word changed while stalled");
    frame_end_a: assert property (take && tx_last_o |=> !tx_valid_o && !tx_last_o)
        else $error("stream did not stop after last word");
    cover property (take && tx_last_o);
    cover property (tx_valid_o && !tx_ready_i);
    cover property (wb_ack_o);
endmodule : bdr_core_chk

// [verif/bdr_sink.sv]
// Receiving end of the report stream; stalls every other cycle when slow
`timescale 1ns/10ps
module bdr_sink (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic        tx_valid_i,
    input  wire logic [15:0] tx_word_i,
    output logic             tx_ready_o,
    output logic [9:0]       rx_n_o
);
    logic [15:0] rx_q [0:299];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ready_o <= 1'b0;
            rx_n_o     <= 10'h000;
        end else begin
            tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
            if (tx_valid_i && tx_ready_o) begin
                rx_q[rx_n_o] <= tx_word_i;
                rx_n_o       <= rx_n_o + 10'h001;
            end
        end
    end
endmodule : bdr_sink

// [verif/bdr_core_test.sv]
// Self-checking bench for the boot diagnostic report block
`timescale 1ns/10ps
`include "bdr_defs.svh"
module bdr_core_test;
    logic        clk_i, rst_i, cyc, stb, we, irq, slow;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0]  sel, fp_i;
    logic        ack, sbi_v, fp_v, prom, pm_v, dw, dr, ee_v, t_done, c_done, c_fail;
    logic [2:0]  sbi_ph, sbi_rg;
    logic [15:0] sbi_d, tx_w;
    logic [31:0] fp_d;
    logic [16:0] pm_a;
    logic [18:0] ee_a;
    logic        tx_v, tx_l, tx_r;
    logic [9:0]  rx_n;
    logic [15:0] exp_w [0:295];
    int          mismatches, checked;

    bdr_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .sbi_obs_valid_i(sbi_v), .sbi_obs_phase_i(sbi_ph), .sbi_obs_reg_i(sbi_rg), .sbi_obs_data_i(sbi_d),
        .fpga_obs_valid_i(fp_v), .fpga_obs_idx_i(fp_i), .fpga_obs_data_i(fp_d), .prom_fail_i(prom),
        .pm_err_valid_i(pm_v), .pm_err_addr_i(pm_a), .dmram_wr_fail_i(dw), .dmram_restore_fail_i(dr),
        .ee_err_valid_i(ee_v), .ee_err_addr_i(ee_a), .tests_done_i(t_done), .asw_copy_done_i(c_done),
        .asw_copy_fail_i(c_fail), .tx_valid_o(tx_v), .tx_word_o(tx_w), .tx_last_o(tx_l), .tx_ready_i(tx_r));
    bdr_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .tx_valid_i(tx_v), .tx_word_i(tx_w),
        .tx_ready_o(tx_r), .rx_n_o(rx_n));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = !clk_i;
    end

    task automatic end_of_test;
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Waits up to 50 cycles for the answer, then ends the run as failed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
    endtask : wb

    task automatic t_regs;
        wb(1'b0, `BDR_A_CTRL, 32'h0);
        chk(q, 32'h00000001);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h00000000);
        wb(1'b0, `BDR_A_IRQ_MASK, 32'h0);
        chk(q, 32'h00000000);
        wb(1'b1, `BDR_A_IRQ_MASK, 32'h00000001);
        wb(1'b0, `BDR_A_IRQ_MASK, 32'h0);
        chk(q, 32'h00000001);
    endtask : t_regs

    task automatic t_sbi;
        logic [21:0] tab [8] = '{22'h020005, 22'h080000, 22'h0B0000, 22'h140001, 22'h100000, 22'h18AAAA,
                                 22'h205554, 22'h280000};
        for (int i = 0; i < 8; i++) begin
            {sbi_v, sbi_ph, sbi_rg, sbi_d} <= {1'b1, tab[i]};
            @(posedge clk_i);
        end
        sbi_v <= 1'b0;
        wb(1'b0, `BDR_A_SBI, 32'h0);
        chk(q, 32'h00000017);
    endtask : t_sbi

    task automatic t_fpga;
        logic [31:0] e;
        for (int i = 0; i < 16; i++) begin
            case (i)
                3: e = 32'h01FF0000;
                5, 6: e = 32'h00640000;
                8: e = 32'h0A5AA5A5;
                default: e = 32'h0;
            endcase
            // Bits 3, 8 and 13 get a readback one off from the reset value
            {fp_v, fp_i, fp_d} <= {1'b1, 4'(i), e ^ {31'h0, (i == 3 || i == 8 || i == 13)}};
            @(posedge clk_i);
        end
        fp_v <= 1'b0;
        wb(1'b0, `BDR_A_FPGA, 32'h0);
        chk(q, 32'h00002108);
    endtask : t_fpga

    task automatic t_mem;
        logic [16:0] a;
        logic [18:0] e;
        for (int i = 0; i < 296; i++) exp_w[i] = 16'h0;
        {prom, dr} <= 2'b11;
        @(posedge clk_i);
        {prom, dr} <= 2'b00;
        // Seventeen back-to-back errors: the last one overflows the address list
        for (int i = 0; i < 17; i++) begin
            a = 17'(i * 32'h2008);
            {pm_v, pm_a} <= {1'b1, a};
            exp_w[6 + a[16:10]][a[9:6]] = 1'b1;
            if (i < 16) exp_w[134 + 2 * i] = {15'h0, a[16]};
            if (i < 16) exp_w[135 + 2 * i] = a[15:0];
            @(posedge clk_i);
        end
        pm_v <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            e = k ? 19'h7FF00 : 19'h00100;
            {ee_v, ee_a} <= {1'b1, e};
            exp_w[167 + e[18:12]][e[11:8]] = 1'b1;
            @(posedge clk_i);
        end
        ee_v <= 1'b0;
        wb(1'b0, `BDR_A_STATUS, 32'h0);
        chk(q & 32'h000001F1, 32'h00000100);
        chk({31'h0, irq}, 32'h0);
    endtask : t_mem

    task automatic t_report;
        int n;
        {exp_w[0], exp_w[1], exp_w[2]} = {16'h0257, 16'h031A, 16'h0001};
        {exp_w[3], exp_w[4], exp_w[5]} = {16'h0017, 16'h2108, 16'h0001};
        {exp_w[166], exp_w[295]} = {16'h0002, 16'h0001};
        {slow, c_done, c_fail} <= 3'b111;
        @(posedge clk_i);
        {c_done, c_fail} <= 2'b00;
        n = 0;
        while (rx_n !== 10'd296 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            mismatches++;
            end_of_test();
        end
        for (int i = 0; i < 296; i++) chk({16'h0, sink_u.rx_q[i]}, {16'h0, exp_w[i]});
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        {slow, t_done} <= 2'b01;
        @(posedge clk_i);
        t_done <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk({22'h0, rx_n}, 32'd296);
        wb(1'b0, `BDR_A_IRQ_STAT, 32'h0);
        chk(q, 32'h00000003);
        wb(1'b1, `BDR_A_IRQ_STAT, 32'h00000003);
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        // Clear-results wipes collected flags but does not rearm the report
        wb(1'b1, `BDR_A_CTRL, 32'h00000003);
        wb(1'b0, `BDR_A_SBI, 32'h0);
        chk(q, 32'h00000000);
        wb(1'b0, `BDR_A_STATUS, 32'h0);
        chk(q, 32'h00000001);
    endtask : t_report

    initial begin
        {cyc, stb, we, adr, wdat, sbi_v, sbi_ph, sbi_rg, sbi_d, fp_v, fp_i, fp_d} = '0;
        {prom, pm_v, pm_a, dw, dr, ee_v, ee_a, t_done, c_done, c_fail, slow} = '0;
        {rst_i, sel} = 5'h1F;
        mismatches = 0;
        checked = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_sbi();
        t_fpga();
        t_mem();
        t_report();
        end_of_test();
    end
endmodule : bdr_core_test

bind bdr_core bdr_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .tests_done_i(tests_done_i), .asw_copy_done_i(asw_copy_done_i),
    .tx_valid_o(tx_valid_o), .tx_word_o(tx_word_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));
